/* File: design/udp_pkg.sv */
// How it works
// - Power-on, hardware standby, reset pin clear port.
// - Soft reset or module stop bit clears port.
// - Software standby keeps buffers, mode and state.
// - Monitor standby: keep answering not-ready, never complete.
// - Monitor standby: link protocol keeps sampling, driving.
// - Trace output freezes in standby, then resumes.
// - Not-ready reads 0000, ready reads 0001, with bit 1 set on a command error and bit 2 on a bus error.
package udp_pkg;
  localparam logic [7:0] REG_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] REG_MODULE_STOP = 8'h04;
  localparam logic [7:0] REG_PORT_STATUS = 8'h08;
  localparam int SOFT_RESET_POS = 0;
  localparam int MODULE_STOP_POS = 0;
  localparam int STAT_MODE_POS = 0;
  localparam int STAT_CLEAR_POS = 1;
  localparam int STAT_BUSY_POS = 2;
  localparam int STAT_TRACE_POS = 3;
  localparam logic [3:0] NIB_NOT_READY = 4'h0;
  localparam logic [3:0] NIB_READY = 4'h1;
  localparam int ERR_CMD_POS = 1;
  localparam int ERR_BUS_POS = 2;
  localparam logic [3:0] NIB_TRACE_IDLE = 4'h3;
  localparam logic [1:0] TRACE_HDR = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [3:0] ADDR_NIBBLES = 4'h8;
  localparam int PIN_SYNC_W = 5;
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_WDATA, M_EXEC, M_DONE, M_RDATA} udp_mon_t;
  typedef enum logic [1:0] {T_IDLE, T_HDR, T_ADDR} udp_trace_t;
endpackage

/* File: design/udp_port.sv */
module udp_port
  import udp_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic debug_clock_in,
  input wire logic debug_reset_n,
  input wire logic debug_mode_select,
  input wire logic debug_sync_n_in,
  output logic debug_sync_n_out,
  output logic debug_sync_n_oe,
  input wire logic [3:0] debug_nibble_bus_in,
  output logic [3:0] debug_nibble_bus_out,
  output logic debug_nibble_bus_oe,
  input wire logic branch_valid,
  input wire logic [31:0] branch_addr,
  output logic bus_req,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic [1:0] bus_size,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);
  logic [PIN_SYNC_W-1:0] pin_s1;
  logic [PIN_SYNC_W-1:0] pin_s2;
  logic clk_q;
  logic rstpin_q;
  logic link_rise;
  logic link_fall;
  logic rstpin_release;
  logic sync_low;
  logic [3:0] nib_in;
  logic soft_reset;
  logic module_stop;
  logic port_clear;
  logic mode_ram;
  udp_mon_t mstate;
  udp_trace_t tstate;
  logic [3:0] cnt;
  logic cmd_write;
  logic [1:0] cmd_size;
  logic [31:0] acc_addr;
  logic [DATA_W-1:0] acc_data;
  logic err_cmd;
  logic err_bus;
  logic branch_pend;
  logic [31:0] pend_addr;
  logic [31:0] shift_addr;
  logic [31:0] last_full;
  logic [1:0] tsize;
  logic [3:0] cnt_trace;

  function automatic logic [3:0] data_nibbles(input logic [1:0] size);
    data_nibbles = 4'h2 << size;
  endfunction

  function automatic logic misaligned(input logic [1:0] size, input logic [31:0] addr);
    misaligned = (size == SIZE_WORD && addr[0]) || (size == SIZE_LONG && addr[1:0] != 2'h0);
  endfunction

  // Chooses 4, 8, 16 or 32 address bits against the last fully sent address.
  function automatic logic [1:0] trace_size(input logic [31:0] a, input logic [31:0] b);
    if (a[31:4] == b[31:4]) begin
      trace_size = 2'h0;
    end else if (a[31:8] == b[31:8]) begin
      trace_size = 2'h1;
    end else if (a[31:16] == b[31:16]) begin
      trace_size = 2'h2;
    end else begin
      trace_size = 2'h3;
    end
  endfunction

  // Pins from the tool pass two flip-flops; only the second stage is read.
  // The clock and nibble pins reset to the pulled-up idle level so that no false link edge follows reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
    end else begin
      pin_s1 <= {debug_nibble_bus_in, debug_clock_in} ^ 5'h00;
      pin_s2 <= pin_s1;
    end
  end

  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_s1 <= 3'h0;
      ctl_s2 <= 3'h0;
    end else begin
      ctl_s1 <= {debug_mode_select, debug_sync_n_in, debug_reset_n};
      ctl_s2 <= ctl_s1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_q <= 1'b1;
      rstpin_q <= 1'b0;
    end else begin
      clk_q <= pin_s2[0];
      rstpin_q <= ctl_s2[0];
    end
  end

  assign link_rise = pin_s2[0] & ~clk_q;
  assign link_fall = ~pin_s2[0] & clk_q;
  assign rstpin_release = ctl_s2[0] & ~rstpin_q;
  assign sync_low = ~ctl_s2[1];
  assign nib_in = pin_s2[4:1];
  assign port_clear = hw_standby | ~ctl_s2[0] | soft_reset | module_stop;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_reset <= 1'b0;
      module_stop <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == REG_SYSTEM_CONTROL) begin
        soft_reset <= reg_wdata[SOFT_RESET_POS];
      end
      if (reg_addr == REG_MODULE_STOP) begin
        module_stop <= reg_wdata[MODULE_STOP_POS];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        REG_SYSTEM_CONTROL: reg_rdata[SOFT_RESET_POS] <= soft_reset;
        REG_MODULE_STOP: reg_rdata[MODULE_STOP_POS] <= module_stop;
        REG_PORT_STATUS: begin
          reg_rdata[STAT_MODE_POS] <= mode_ram;
          reg_rdata[STAT_CLEAR_POS] <= port_clear;
          reg_rdata[STAT_BUSY_POS] <= mstate != M_IDLE;
          reg_rdata[STAT_TRACE_POS] <= tstate != T_IDLE;
        end
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // The mode pin is caught when the tool releases the reset pin.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_ram <= 1'b0;
    end else if (rstpin_release) begin
      mode_ram <= ctl_s2[2];
    end
  end

  // Software standby is absent from every clear term, so all state holds through it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mstate <= M_IDLE;
      cnt <= 4'h0;
      cmd_write <= 1'b0;
      cmd_size <= SIZE_BYTE;
      acc_addr <= 32'h0000_0000;
      acc_data <= '0;
      err_cmd <= 1'b0;
      err_bus <= 1'b0;
    end else if (port_clear || !mode_ram) begin
      mstate <= M_IDLE;
      cnt <= 4'h0;
      err_cmd <= 1'b0;
      err_bus <= 1'b0;
    end else begin
      unique case (mstate)
        M_IDLE: if (link_rise && sync_low) begin
          cmd_write <= nib_in[3:2] == CMD_WRITE;
          cmd_size <= nib_in[1:0];
          err_cmd <= nib_in[3] != 1'b1 || nib_in[1:0] == 2'h3;
          err_bus <= 1'b0;
          cnt <= 4'h0;
          mstate <= (nib_in[3] != 1'b1 || nib_in[1:0] == 2'h3) ? M_DONE : M_ADDR;
        end
        M_ADDR: if (link_rise) begin
          acc_addr[cnt*4 +: 4] <= nib_in;
          cnt <= cnt + 4'h1;
          if (cnt == ADDR_NIBBLES - 4'h1) begin
            cnt <= 4'h0;
            mstate <= cmd_write ? M_WDATA : M_EXEC;
          end
        end
        M_WDATA: if (link_rise) begin
          acc_data[cnt*4 +: 4] <= nib_in;
          cnt <= cnt + 4'h1;
          if (cnt == data_nibbles(cmd_size) - 4'h1) begin
            cnt <= 4'h0;
            mstate <= M_EXEC;
          end
        end
        M_EXEC: if (misaligned(cmd_size, acc_addr)) begin
          err_bus <= 1'b1;
          mstate <= M_DONE;
        end else if (bus_req && (bus_ack || bus_err)) begin
          err_bus <= bus_err;
          if (!cmd_write) begin
            acc_data <= bus_rdata;
          end
          mstate <= M_DONE;
        end
        M_DONE: if (link_fall && !sync_low && !sw_standby) begin
          cnt <= 4'h1;
          mstate <= (!cmd_write && !err_cmd && !err_bus) ? M_RDATA : M_IDLE;
        end
        M_RDATA: if (link_fall) begin
          cnt <= cnt + 4'h1;
          if (cnt == data_nibbles(cmd_size)) begin
            mstate <= M_IDLE;
          end
        end
      endcase
    end
  end

  // No access is started in software standby; it is started once standby ends.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_req <= 1'b0;
    end else if (port_clear || !mode_ram) begin
      bus_req <= 1'b0;
    end else if (bus_req && (bus_ack || bus_err)) begin
      bus_req <= 1'b0;
    end else if (mstate == M_EXEC && !bus_req && !sw_standby && !misaligned(cmd_size, acc_addr)) begin
      bus_req <= 1'b1;
    end
  end

  assign bus_write = cmd_write;
  assign bus_addr = acc_addr;
  assign bus_wdata = acc_data;
  assign bus_size = cmd_size;

  // A new branch overrides an older pending one; the set wins over the take.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      branch_pend <= 1'b0;
      pend_addr <= 32'h0000_0000;
    end else if (port_clear || mode_ram) begin
      branch_pend <= 1'b0;
    end else if (branch_valid) begin
      branch_pend <= 1'b1;
      pend_addr <= branch_addr;
    end else if (link_fall && !sw_standby && branch_pend) begin
      branch_pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tstate <= T_IDLE;
      tsize <= 2'h0;
      shift_addr <= 32'h0000_0000;
      last_full <= 32'h0000_0000;
    end else if (port_clear || mode_ram) begin
      tstate <= T_IDLE;
      last_full <= 32'h0000_0000;
    end else if (link_fall && !sw_standby) begin
      if (branch_pend) begin
        tstate <= T_HDR;
        tsize <= trace_size(pend_addr, last_full);
        shift_addr <= pend_addr;
      end else begin
        unique case (tstate)
          T_IDLE: tstate <= T_IDLE;
          T_HDR: begin
            tstate <= T_ADDR;
          end
          T_ADDR: begin
            if (cnt_trace == (4'h1 << tsize) - 4'h1) begin
              tstate <= T_IDLE;
              last_full <= shift_addr;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_trace <= 4'h0;
    end else if (port_clear || mode_ram) begin
      cnt_trace <= 4'h0;
    end else if (link_fall && !sw_standby) begin
      cnt_trace <= (tstate == T_ADDR && !branch_pend) ? cnt_trace + 4'h1 : 4'h0;
    end
  end

  // Pins change on the link clock's falling edge so the tool samples on its rise.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      debug_nibble_bus_out <= 4'h0;
      debug_nibble_bus_oe <= 1'b0;
      debug_sync_n_out <= 1'b1;
      debug_sync_n_oe <= 1'b0;
    end else if (port_clear) begin
      debug_nibble_bus_oe <= 1'b0;
      debug_sync_n_oe <= 1'b0;
      debug_sync_n_out <= 1'b1;
    end else if (mode_ram) begin
      debug_sync_n_oe <= 1'b0;
      if (link_fall) begin
        debug_nibble_bus_oe <= mstate == M_EXEC || mstate == M_DONE || mstate == M_RDATA;
        if (mstate == M_EXEC || (mstate == M_DONE && sw_standby)) begin
          debug_nibble_bus_out <= NIB_NOT_READY;
        end else if (mstate == M_DONE && sync_low) begin
          debug_nibble_bus_out <= NIB_READY | ({3'h0, err_cmd} << ERR_CMD_POS) | ({3'h0, err_bus} << ERR_BUS_POS);
        end else if (mstate == M_RDATA && cnt == data_nibbles(cmd_size)) begin
          // The releasing fall reads no nibble, so a longword never indexes past the data.
          debug_nibble_bus_oe <= 1'b0;
        end else if (mstate == M_DONE || mstate == M_RDATA) begin
          debug_nibble_bus_out <= acc_data[(mstate == M_DONE ? 4'h0 : cnt)*4 +: 4];
          if (mstate == M_DONE && (cmd_write || err_cmd || err_bus)) begin
            debug_nibble_bus_oe <= 1'b0;
          end
        end
      end
    end else begin
      debug_nibble_bus_oe <= 1'b1;
      debug_sync_n_oe <= 1'b1;
      if (link_fall && !sw_standby) begin
        if (branch_pend) begin
          debug_nibble_bus_out <= {TRACE_HDR, trace_size(pend_addr, last_full)};
          debug_sync_n_out <= 1'b1;
        end else if (tstate == T_HDR || (tstate == T_ADDR && cnt_trace != (4'h1 << tsize) - 4'h1)) begin
          debug_nibble_bus_out <= shift_addr[(tstate == T_HDR ? 4'h0 : cnt_trace + 4'h1)*4 +: 4];
          debug_sync_n_out <= 1'b0;
        end else begin
          debug_nibble_bus_out <= NIB_TRACE_IDLE;
          debug_sync_n_out <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: testbench/udp_port_properties.sv */
module udp_port_chk
  import udp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic debug_reset_n,
  input wire logic debug_sync_n_in,
  input wire logic debug_sync_n_out,
  input wire logic debug_sync_n_oe,
  input wire logic [3:0] debug_nibble_bus_out,
  input wire logic debug_nibble_bus_oe,
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_HW_CLEAR: assert property (hw_standby [*5] |-> !bus_req && !debug_nibble_bus_oe && !debug_sync_n_oe)
    else $error("port active in hardware standby");
  AST_PIN_CLEAR: assert property (!debug_reset_n [*5] |-> !bus_req && !debug_nibble_bus_oe && !debug_sync_n_oe)
    else $error("port active while reset pin low");
  AST_SOFT_CLEAR: assert property (reg_write && reg_addr == REG_SYSTEM_CONTROL && reg_wdata[SOFT_RESET_POS]
    |-> ##4 !bus_req && !debug_sync_n_oe) else $error("soft reset did not clear port");
  AST_STOP_CLEAR: assert property (reg_write && reg_addr == REG_MODULE_STOP && reg_wdata[MODULE_STOP_POS]
    |-> ##4 !bus_req && !debug_sync_n_oe) else $error("module stop did not clear port");
  AST_STANDBY_STATE_NOT_READY: assert property (sw_standby [*8] ##0 (!debug_sync_n_in && !debug_sync_n_oe
    && debug_nibble_bus_oe) |-> debug_nibble_bus_out == NIB_NOT_READY) else $error("ready shown in standby");
  AST_BUSY_NOT_READY: assert property (bus_req && debug_nibble_bus_oe && !debug_sync_n_oe
    |-> debug_nibble_bus_out == NIB_NOT_READY) else $error("status not 0000 during access");
  AST_TRACE_FREEZE: assert property (sw_standby [*6] ##0 debug_sync_n_oe
    |-> $stable(debug_nibble_bus_out) && $stable(debug_sync_n_out)) else $error("trace moved in standby");
  AST_STANDBY_STATE_KEEPS_MODE: assert property (sw_standby && debug_reset_n && !hw_standby && debug_sync_n_oe
    |=> debug_sync_n_oe) else $error("standby cleared trace port");
  AST_STANDBY_STATE_KEEPS_REQ: assert property (sw_standby && bus_req && !bus_ack && !bus_err
    |=> bus_req && $stable(bus_addr)) else $error("standby dropped pending access");
endmodule

bind udp_port udp_port_chk chk_u (.mclk(mclk), .rst(rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
  .debug_reset_n(debug_reset_n), .debug_sync_n_in(debug_sync_n_in), .debug_sync_n_out(debug_sync_n_out),
  .debug_sync_n_oe(debug_sync_n_oe), .debug_nibble_bus_out(debug_nibble_bus_out),
  .debug_nibble_bus_oe(debug_nibble_bus_oe), .bus_req(bus_req), .bus_ack(bus_ack), .bus_err(bus_err),
  .bus_addr(bus_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write));

/* File: testbench/udp_port_tb.sv */
module udp_port_tb import udp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic debug_reset_n = 1'b0;
  logic debug_mode_select = 1'b1;
  logic branch_valid = 1'b0;
  logic [31:0] branch_addr = 32'h0;
  logic bus_ack = 1'b0;
  logic [31:0] bus_rdata = 32'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic link_clk, t_sync, t_oe, sync_out, sync_oe, sync_w, nib_oe, bus_req, bus_write;
  logic [3:0] t_nib, nib_out, nib_w;
  logic [1:0] bus_size;
  logic [31:0] bus_addr, bus_wdata, reg_rdata;
  int miscompares = 0;
  int checks_done = 0;
  // The nibble lines are pulled up when nobody drives them; sync follows the tool whenever the port does not drive it.
  assign nib_w = nib_oe ? nib_out : (t_oe ? t_nib : 4'hf);
  assign sync_w = sync_oe ? sync_out : t_sync;
  always #50 mclk = ~mclk;
  udp_port dut_u (.mclk(mclk), .rst(rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .debug_clock_in(link_clk), .debug_reset_n(debug_reset_n), .debug_mode_select(debug_mode_select),
    .debug_sync_n_in(sync_w), .debug_sync_n_out(sync_out), .debug_sync_n_oe(sync_oe),
    .debug_nibble_bus_in(nib_w), .debug_nibble_bus_out(nib_out), .debug_nibble_bus_oe(nib_oe),
    .branch_valid(branch_valid), .branch_addr(branch_addr), .bus_req(bus_req), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_ack(bus_ack), .bus_err(1'b0),
    .bus_rdata(bus_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  udp_tool_model tool_u (.link_clk(link_clk), .sync_n(t_sync), .nib(t_nib), .nib_oe(t_oe), .nib_w(nib_w),
    .sync_w(sync_w));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_req();
    for (int i = 0; i < 100 && bus_req !== 1'b1; i++) begin
      @(posedge mclk);
    end
    if (bus_req !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic scen_monitor();
    logic [4:0] q;
    logic [31:0] d;
    tool_u.tick(1'b0, 1'b1, 4'h8, q);
    for (int i = 0; i < 8; i++) begin
      tool_u.tick(1'b0, 1'b1, 4'(32'h1234 >> (4 * i)), q);
    end
    wait_req();
    chk(bus_addr, 32'h1234);
    chk({bus_write, bus_size}, {1'b0, SIZE_BYTE});
    tool_u.tick(1'b0, 1'b0, 4'h0, q);
    chk(q, {1'b0, NIB_NOT_READY});
    @(posedge mclk);
    sw_standby <= 1'b1;
    reg_rd(REG_PORT_STATUS, d);
    chk(d, 32'h5);
    @(posedge mclk);
    bus_ack <= 1'b1;
    bus_rdata <= 32'h5a5a5a5a;
    @(posedge mclk);
    bus_ack <= 1'b0;
    repeat (3) begin
      tool_u.tick(1'b0, 1'b0, 4'h0, q);
      chk(q, {1'b0, NIB_NOT_READY});
    end
    @(posedge mclk);
    sw_standby <= 1'b0;
    repeat (2) begin
      tool_u.tick(1'b0, 1'b0, 4'h0, q);
    end
    chk(q, {1'b0, NIB_READY});
    tool_u.tick(1'b1, 1'b0, 4'h0, q);
    chk(q[3:0], 4'ha);
    tool_u.tick(1'b1, 1'b0, 4'h0, q);
    chk(q[3:0], 4'h5);
    // After the last data nibble the port lets the lines go to their pull-ups.
    tool_u.tick(1'b1, 1'b0, 4'h0, q);
    chk(q, 5'h1f);
  endtask
  task automatic scen_write();
    logic [4:0] q;
    tool_u.tick(1'b0, 1'b1, 4'hc, q);
    // Eight address nibbles, then the two data nibbles, lowest first.
    for (int i = 0; i < 10; i++) begin
      tool_u.tick(1'b0, 1'b1, 4'(40'h3c_0000_1236 >> (4 * i)), q);
    end
    wait_req();
    chk(bus_addr, 32'h1236);
    chk({bus_write, bus_size}, {1'b1, SIZE_BYTE});
    chk(bus_wdata[7:0], 8'h3c);
    @(posedge mclk);
    bus_ack <= 1'b1;
    @(posedge mclk);
    bus_ack <= 1'b0;
    tool_u.tick(1'b0, 1'b0, 4'h0, q);
    chk(q, {1'b0, NIB_READY});
    tool_u.tick(1'b1, 1'b0, 4'h0, q);
    chk(q, 5'h1f);
  endtask
  task automatic scen_trace();
    logic [4:0] q;
    logic [4:0] exp_q [3] = '{5'h18, 5'h05, 5'h13};
    @(posedge mclk);
    debug_reset_n <= 1'b0;
    debug_mode_select <= 1'b0;
    repeat (4) @(posedge mclk);
    debug_reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    tool_u.tick(1'b1, 1'b0, 4'h0, q);
    chk(q, {1'b1, NIB_TRACE_IDLE});
    @(posedge mclk);
    branch_valid <= 1'b1;
    branch_addr <= 32'h5;
    @(posedge mclk);
    branch_valid <= 1'b0;
    sw_standby <= 1'b1;
    repeat (2) begin
      tool_u.tick(1'b1, 1'b0, 4'h0, q);
      chk(q, {1'b1, NIB_TRACE_IDLE});
    end
    @(posedge mclk);
    sw_standby <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      tool_u.tick(1'b1, 1'b0, 4'h0, q);
      chk(q, exp_q[i]);
    end
  endtask
  task automatic scen_clear();
    logic [31:0] d;
    reg_rd(8'h10, d);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      for (int v = 1; v >= 0; v--) begin
        @(posedge mclk);
        case (i)
          0: reg_wr(REG_SYSTEM_CONTROL, 32'(v));
          1: reg_wr(REG_MODULE_STOP, 32'(v));
          2: hw_standby <= v[0];
          default: debug_reset_n <= ~v[0];
        endcase
        repeat (5) @(posedge mclk);
        reg_rd(REG_PORT_STATUS, d);
        chk(d[STAT_CLEAR_POS], 32'(v));
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    debug_reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    scen_monitor();
    scen_write();
    scen_trace();
    scen_clear();
    report_and_stop();
  end
endmodule

/* File: testbench/udp_tool_model.sv */
module udp_tool_model (
  output logic link_clk,
  output logic sync_n,
  output logic [3:0] nib,
  output logic nib_oe,
  input wire logic [3:0] nib_w,
  input wire logic sync_w
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_clk = 1'b1;
    sync_n = 1'b1;
    nib = 4'hf;
    nib_oe = 1'b0;
  end
  // One link period; the clock stands high between calls.
  // Lines change 30 ns in, clear of both link edges and of the system clock's edges.
  task automatic tick(input logic s, input logic d, input logic [3:0] n, output logic [4:0] q);
    #30 sync_n = s;
    nib_oe = d;
    nib = n;
    #300 link_clk = 1'b0;
    #400 link_clk = 1'b1;
    #40 q = {sync_w, nib_w};
    #30;
  endtask
endmodule
